// ---- verilog/i2c_burst_defines.svh ----
// Constants shared by both ends of the burst register link
`ifndef I2C_BURST_DEFINES_SVH
`define I2C_BURST_DEFINES_SVH

// ==========================================
// Bus addressing
`define DEV_BUS_ADDR 7'h36
`define DIR_WRITE 1'h0
`define DIR_READ 1'h1

// ==========================================
// Memory space
`define WORD_COUNT 256
`define RO_FIRST 8'hF0
`define RO_LAST 8'hFF
`define FILL_BYTE 8'hFF

// ==========================================
// Timing
`define CLK_PERIOD_NS 100
`define HOST_QUARTER_NS 2500
`define HOST_QUARTER_CYC ((`HOST_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_BUF_DEPTH 2

`endif

// ---- verilog/i2c_burst_pkg.sv ----
// Types shared by both ends of the burst register link
package i2c_burst_pkg;

  // ==========================================
  // Device receiver and transmitter states
  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_PTR, D_WDATA, D_ACK, D_RDATA, D_RACK
  } dev_state_e;

  // ==========================================
  // Master sequencer states and byte roles
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_FETCH, H_BYTE, H_STOP
  } host_state_e;

  typedef enum logic [2:0] {
    S_ADDR_W, S_PTR, S_WDATA, S_ADDR_R, S_RDATA
  } host_step_e;

endpackage

// ---- verilog/i2c_burst_if.sv ----
// Two-wire link between the master end and the device end
`timescale 1ns/1ps
`default_nettype none

interface i2c_burst_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: any enabled driver pulls low
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
                input scl, input sda);
  modport device (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

`default_nettype wire

// ---- verilog/i2c_burst_device.sv ----
// Device end: two-wire slave with burst access to a word memory
`timescale 1ns/1ps
`default_nettype none
`include "i2c_burst_defines.svh"

// Contract
// - Write: start, address+W, pointer, low/high pairs, stop
// - First data bit follows pointer acknowledge directly
// - Write pointer advances after each data byte
// - Write data beyond top address is dropped
// - Writes to read-only words are dropped
// - Master never writes reserved locations
// - Read: pointer write, repeated start, address+R
// - Read data starts MSb at start address
// - Read pointer advances after each sent byte
// - Reads beyond top address return all ones
// - Reserved locations read arbitrary values
// - Master ends read with NACK then stop
// - Acknowledge only own fixed seven-bit address
// - Direction bit zero writes, one reads
// - Words go low byte first, MSb first
// - Master ends write with stop after acknowledge
module i2c_burst_device (
  input wire logic clk,
  input wire logic rst,
  i2c_burst_if.device bus,
  input wire logic load_valid,
  output logic load_ready,
  input wire logic [7:0] load_addr,
  input wire logic [15:0] load_data,
  input wire logic [7:0] peek_addr,
  output logic [15:0] peek_data,
  output logic busy
);

  // ==========================================
  // Helpers

  // Byte pointer step, sticking once past the top word
  function automatic logic [9:0] ptr_inc(input logic [9:0] p);
    ptr_inc = p[9] ? p : p + 10'h001;
  endfunction

  // Words that ignore bus writes
  function automatic logic is_read_only(input logic [7:0] w);
    is_read_only = (w >= `RO_FIRST) && (w <= `RO_LAST);
  endfunction

  // ==========================================
  // Pin synchronisers and edge detection
  logic scl_s1, scl_s2, scl_q;
  logic sda_s1, sda_s2, sda_q;

  // Two flops per pin, then one more for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'h1;
      scl_s2 <= 1'h1;
      scl_q <= 1'h1;
      sda_s1 <= 1'h1;
      sda_s2 <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
    end
  end

  logic scl_rise, scl_fall, got_start, got_stop;

  // Start and stop are data edges while the clock stays high
  assign scl_rise = scl_s2 & ~scl_q;
  assign scl_fall = ~scl_s2 & scl_q;
  assign got_start = scl_s2 & scl_q & sda_q & ~sda_s2;
  assign got_stop = scl_s2 & scl_q & ~sda_q & sda_s2;

  // ==========================================
  // Memory and its read port
  logic [15:0] mem [`WORD_COUNT];
  logic [9:0] ptr;
  logic [7:0] cur_byte;
  logic mem_we;
  logic [7:0] mem_wbyte;

  // Byte under the pointer; all ones once past the top
  assign cur_byte = ptr[9] ? `FILL_BYTE : (ptr[0] ? mem[ptr[8:1]][15:8] : mem[ptr[8:1]][7:0]);

  // ==========================================
  // Protocol state
  i2c_burst_pkg::dev_state_e state, next_state;
  i2c_burst_pkg::dev_state_e after, next_after;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [9:0] next_ptr;
  logic sda_low, next_sda_low;
  logic ack_on, next_ack_on;
  logic [7:0] rx_byte;

  // Byte as it completes on the eighth rising edge
  assign rx_byte = {sh[6:0], sda_s2};

  // Next-state logic of the slave engine
  always_comb begin
    next_state = state;
    next_after = after;
    next_cnt = cnt;
    next_sh = sh;
    next_ptr = ptr;
    next_sda_low = sda_low;
    next_ack_on = ack_on;
    mem_we = 1'h0;
    mem_wbyte = rx_byte;
    if (got_stop) begin
      next_state = i2c_burst_pkg::D_IDLE;
      next_sda_low = 1'h0;
      next_ack_on = 1'h0;
    end else if (got_start) begin
      next_state = i2c_burst_pkg::D_ADDR;
      next_cnt = 4'h0;
      next_sda_low = 1'h0;
      next_ack_on = 1'h0;
    end else begin
      case (state)
        i2c_burst_pkg::D_ADDR, i2c_burst_pkg::D_PTR, i2c_burst_pkg::D_WDATA: begin
          if (scl_rise) begin
            next_sh = rx_byte;
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) begin
              next_cnt = 4'h0;
              next_ack_on = 1'h0;
              next_state = i2c_burst_pkg::D_ACK;
              if (state == i2c_burst_pkg::D_ADDR) begin
                if (rx_byte[7:1] == `DEV_BUS_ADDR) begin
                  // Direction bit picks the next phase
                  next_after = (rx_byte[0] == `DIR_READ) ? i2c_burst_pkg::D_RDATA
                                                          : i2c_burst_pkg::D_PTR;
                end else begin
                  next_state = i2c_burst_pkg::D_IDLE;
                end
              end else if (state == i2c_burst_pkg::D_PTR) begin
                next_ptr = {1'h0, rx_byte, 1'h0};
                next_after = i2c_burst_pkg::D_WDATA;
              end else begin
                mem_we = ~ptr[9] & ~is_read_only(ptr[8:1]);
                next_ptr = ptr_inc(ptr);
                next_after = i2c_burst_pkg::D_WDATA;
              end
            end
          end
        end
        i2c_burst_pkg::D_ACK: begin
          if (scl_fall) begin
            if (!ack_on) begin
              next_ack_on = 1'h1;
              next_sda_low = 1'h1;
            end else begin
              next_ack_on = 1'h0;
              next_cnt = 4'h0;
              next_state = after;
              if (after == i2c_burst_pkg::D_RDATA) begin
                next_sh = cur_byte;
                next_sda_low = ~cur_byte[7];
              end else begin
                next_sda_low = 1'h0;
              end
            end
          end
        end
        i2c_burst_pkg::D_RDATA: begin
          if (scl_fall) begin
            next_sh = {sh[6:0], 1'h1};
            next_sda_low = ~sh[6];
          end
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) begin
              next_cnt = 4'h0;
              next_ptr = ptr_inc(ptr);
              next_ack_on = 1'h0;
              next_state = i2c_burst_pkg::D_RACK;
            end
          end
        end
        i2c_burst_pkg::D_RACK: begin
          if (scl_fall) begin
            if (!ack_on) begin
              next_sda_low = 1'h0;
            end else begin
              next_ack_on = 1'h0;
              next_sh = cur_byte;
              next_sda_low = ~cur_byte[7];
              next_state = i2c_burst_pkg::D_RDATA;
            end
          end else if (scl_rise) begin
            if (sda_s2) begin
              next_state = i2c_burst_pkg::D_IDLE;
            end else begin
              next_ack_on = 1'h1;
            end
          end
        end
        default: begin
          next_sda_low = 1'h0;
        end
      endcase
    end
  end

  // Registers of the slave engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= i2c_burst_pkg::D_IDLE;
      after <= i2c_burst_pkg::D_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      ptr <= 10'h000;
      sda_low <= 1'h0;
      ack_on <= 1'h0;
    end else begin
      state <= next_state;
      after <= next_after;
      cnt <= next_cnt;
      sh <= next_sh;
      ptr <= next_ptr;
      sda_low <= next_sda_low;
      ack_on <= next_ack_on;
    end
  end

  // ==========================================
  // Memory writes: bus bytes win over local loads
  assign load_ready = ~mem_we;

  always_ff @(posedge clk) begin
    if (mem_we) begin
      if (ptr[0]) begin
        mem[ptr[8:1]][15:8] <= mem_wbyte;
      end else begin
        mem[ptr[8:1]][7:0] <= mem_wbyte;
      end
    end else if (load_valid) begin
      mem[load_addr] <= load_data;
    end
  end

  // Registered view of one word for local logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peek_data <= 16'h0000;
    end else begin
      peek_data <= mem[peek_addr];
    end
  end

  // ==========================================
  // Pin drive: enable high pulls the data line low
  assign bus.dev_sda_o = 1'h0;
  assign bus.dev_sda_oe = sda_low;
  assign busy = (state != i2c_burst_pkg::D_IDLE);

endmodule

`default_nettype wire

// ---- verilog/i2c_burst_host.sv ----
// Master end: issues burst writes and reads over the two-wire link
`timescale 1ns/1ps
`default_nettype none
`include "i2c_burst_defines.svh"

module i2c_burst_host (
  input wire logic clk,
  input wire logic rst,
  i2c_burst_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic done,
  output logic nack_err
);

  localparam logic [7:0] QUARTER = 8'(`HOST_QUARTER_CYC);

  // ==========================================
  // Data line synchroniser
  logic sda_s1, sda_s2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_s1 <= 1'h1;
      sda_s2 <= 1'h1;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  // ==========================================
  // Read buffer: two entries, stalls the sequencer when full
  logic [7:0] rx, next_rx;
  logic [7:0] rbuf [`RD_BUF_DEPTH];
  logic rwp, rrp;
  logic [1:0] rcount;
  logic push, pop;

  assign rd_valid = (rcount != 2'h0);
  assign rd_data = rbuf[rrp];
  assign pop = rd_valid & rd_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rwp <= 1'h0;
      rrp <= 1'h0;
      rcount <= 2'h0;
    end else begin
      rwp <= rwp ^ push;
      rrp <= rrp ^ pop;
      rcount <= rcount + {1'h0, push} - {1'h0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      rbuf[rwp] <= rx;
    end
  end

  // ==========================================
  // Sequencer state
  i2c_burst_pkg::host_state_e state, next_state;
  i2c_burst_pkg::host_step_e step, next_step;
  logic [7:0] div, next_div;
  logic [1:0] q, next_q;
  logic [3:0] bit_i, next_bit_i;
  logic [7:0] tx, next_tx;
  logic [7:0] remaining, next_remaining;
  logic is_read, next_is_read;
  logic [7:0] ptr, next_ptr;
  logic scl_low, next_scl_low;
  logic sda_low, next_sda_low;
  logic bad, next_bad;
  logic next_done, next_nack_err;
  logic tick, rx_kind;

  assign tick = (div == QUARTER - 8'h01);
  assign rx_kind = (step == i2c_burst_pkg::S_RDATA);
  assign cmd_ready = (state == i2c_burst_pkg::H_IDLE);
  assign wr_ready = (state == i2c_burst_pkg::H_FETCH) & ~is_read;

  // Next-state logic of the sequencer
  always_comb begin
    next_state = state;
    next_step = step;
    next_div = div;
    next_q = q;
    next_bit_i = bit_i;
    next_tx = tx;
    next_rx = rx;
    next_remaining = remaining;
    next_is_read = is_read;
    next_ptr = ptr;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_bad = bad;
    next_done = 1'h0;
    next_nack_err = nack_err;
    push = 1'h0;
    if (state != i2c_burst_pkg::H_IDLE && state != i2c_burst_pkg::H_FETCH) begin
      next_div = tick ? 8'h00 : div + 8'h01;
      if (tick) begin
        next_q = q + 2'h1;
      end
    end
    case (state)
      i2c_burst_pkg::H_IDLE: begin
        if (cmd_valid) begin
          next_state = i2c_burst_pkg::H_START;
          next_step = i2c_burst_pkg::S_ADDR_W;
          next_tx = {`DEV_BUS_ADDR, `DIR_WRITE};
          next_is_read = cmd_read;
          next_ptr = cmd_ptr;
          next_remaining = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
          next_nack_err = 1'h0;
          next_div = 8'h00;
          next_q = 2'h0;
        end
      end
      i2c_burst_pkg::H_START: begin
        // Release data, raise clock, pull data low, lower clock
        if (tick) begin
          case (q)
            2'h0: next_sda_low = 1'h0;
            2'h1: next_scl_low = 1'h0;
            2'h2: next_sda_low = 1'h1;
            default: begin
              next_scl_low = 1'h1;
              next_bit_i = 4'h0;
              next_state = i2c_burst_pkg::H_BYTE;
            end
          endcase
        end
      end
      i2c_burst_pkg::H_FETCH: begin
        next_bit_i = 4'h0;
        next_q = 2'h0;
        if (!is_read && wr_valid) begin
          next_tx = wr_data;
          next_state = i2c_burst_pkg::H_BYTE;
        end else if (is_read && rcount != 2'h2) begin
          next_state = i2c_burst_pkg::H_BYTE;
        end
      end
      i2c_burst_pkg::H_BYTE: begin
        if (tick) begin
          case (q)
            2'h0: begin
              // Data changes only while the clock is low
              if (bit_i != 4'h8) begin
                next_sda_low = rx_kind ? 1'h0 : ~tx[7];
              end else begin
                next_sda_low = rx_kind & (remaining != 8'h01);
              end
            end
            2'h1: next_scl_low = 1'h0;
            2'h2: begin
              if (bit_i == 4'h8) begin
                next_bad = ~rx_kind & sda_s2;
              end else begin
                next_rx = {rx[6:0], sda_s2};
              end
            end
            default: begin
              next_scl_low = 1'h1;
              next_tx = {tx[6:0], 1'h1};
              next_bit_i = bit_i + 4'h1;
              if (bit_i == 4'h8) begin
                next_bit_i = 4'h0;
                case (step)
                  i2c_burst_pkg::S_ADDR_W: begin
                    next_tx = ptr;
                    next_step = i2c_burst_pkg::S_PTR;
                    if (bad) begin
                      next_nack_err = 1'h1;
                      next_state = i2c_burst_pkg::H_STOP;
                    end
                  end
                  i2c_burst_pkg::S_PTR: begin
                    if (is_read) begin
                      next_tx = {`DEV_BUS_ADDR, `DIR_READ};
                      next_step = i2c_burst_pkg::S_ADDR_R;
                      next_state = i2c_burst_pkg::H_START;
                    end else begin
                      next_step = i2c_burst_pkg::S_WDATA;
                      next_state = i2c_burst_pkg::H_FETCH;
                    end
                  end
                  i2c_burst_pkg::S_ADDR_R: begin
                    next_step = i2c_burst_pkg::S_RDATA;
                    next_state = bad ? i2c_burst_pkg::H_STOP : i2c_burst_pkg::H_FETCH;
                    next_nack_err = bad;
                  end
                  default: begin
                    push = rx_kind;
                    next_remaining = remaining - 8'h01;
                    // Stop only after the last acknowledge bit
                    next_state = (remaining == 8'h01) ? i2c_burst_pkg::H_STOP
                                                      : i2c_burst_pkg::H_FETCH;
                  end
                endcase
              end
            end
          endcase
        end
      end
      i2c_burst_pkg::H_STOP: begin
        // Clock low with data low, raise clock, then release data
        if (tick) begin
          case (q)
            2'h0: next_sda_low = 1'h1;
            2'h1: next_scl_low = 1'h0;
            2'h2: next_sda_low = 1'h0;
            default: begin
              next_done = 1'h1;
              next_state = i2c_burst_pkg::H_IDLE;
            end
          endcase
        end
      end
      default: next_state = i2c_burst_pkg::H_IDLE;
    endcase
  end

  // Registers of the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= i2c_burst_pkg::H_IDLE;
      step <= i2c_burst_pkg::S_ADDR_W;
      div <= 8'h00;
      q <= 2'h0;
      bit_i <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      remaining <= 8'h00;
      is_read <= 1'h0;
      ptr <= 8'h00;
      scl_low <= 1'h0;
      sda_low <= 1'h0;
      bad <= 1'h0;
      done <= 1'h0;
      nack_err <= 1'h0;
    end else begin
      state <= next_state;
      step <= next_step;
      div <= next_div;
      q <= next_q;
      bit_i <= next_bit_i;
      tx <= next_tx;
      rx <= next_rx;
      remaining <= next_remaining;
      is_read <= next_is_read;
      ptr <= next_ptr;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      bad <= next_bad;
      done <= next_done;
      nack_err <= next_nack_err;
    end
  end

  // ==========================================
  // Open-drain pin drive
  assign bus.host_scl_o = 1'h0;
  assign bus.host_scl_oe = scl_low;
  assign bus.host_sda_o = 1'h0;
  assign bus.host_sda_oe = sda_low;

endmodule

`default_nettype wire

// ---- tb/i2c_burst_properties.sv ----
// Wire-level checks on the two-wire burst link
`timescale 1ns/1ps
`default_nettype none
`include "i2c_burst_defines.svh"

module i2c_burst_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_n;
  logic [7:0] byte_n;
  logic [7:0] shift;
  logic rd_frame;
  logic nacked;
  logic start_c;
  logic rise_c;

  // ==========================================
  // Frame tracking
  // Start and clock-rise detection
  assign start_c = scl & scl_q & sda_q & ~sda;
  assign rise_c = scl & ~scl_q;

  // Bit and byte position, direction and last master answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      bit_n <= 4'h0;
      byte_n <= 8'h0;
      shift <= 8'h0;
      rd_frame <= 1'h0;
      nacked <= 1'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_c) begin
        bit_n <= 4'h0;
        byte_n <= 8'h0;
        nacked <= 1'h0;
      end else if (rise_c) begin
        shift <= {shift[6:0], sda};
        bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
        byte_n <= (bit_n == 4'h8) ? byte_n + 8'h1 : byte_n;
        if (byte_n == 8'h0 && bit_n == 4'h7) rd_frame <= sda;
        if (rd_frame && byte_n != 8'h0 && bit_n == 4'h8) nacked <= sda;
      end
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Device lets go of the data line shortly after a clock fall
  sequence s_release;
    ##[1:5] (!dev_sda_oe [*4]);
  endsequence

  a_addr_ack_match: assert property (rise_c && byte_n == 8'h0 && bit_n == 4'h8 |-> sda == (shift[7:1] != `DEV_BUS_ADDR))
    else $error("address acknowledge wrong");
  a_write_dev_quiet: assert property (rise_c && !rd_frame && byte_n != 8'h0 && bit_n != 4'h8 |-> !dev_sda_oe)
    else $error("device drives during write data");
  a_write_byte_ack: assert property (rise_c && !rd_frame && byte_n != 8'h0 && bit_n == 4'h8 |-> dev_sda_oe && !sda)
    else $error("write byte not acknowledged");
  a_ack_then_release: assert property ($fell(scl) && !rd_frame && byte_n != 8'h0 && bit_n == 4'h0 |-> s_release)
    else $error("device holds line after acknowledge");
  a_read_host_quiet: assert property (rise_c && rd_frame && byte_n != 8'h0 && bit_n != 4'h8 && !nacked |-> !host_sda_oe)
    else $error("master drives during read data");
  a_read_ack_free: assert property (rise_c && rd_frame && byte_n != 8'h0 && bit_n == 4'h8 |-> !dev_sda_oe)
    else $error("device drives master acknowledge slot");
  a_nack_release: assert property ($fell(scl) && nacked |-> s_release)
    else $error("device keeps line after no-acknowledge");
  a_data_stable: assert property (scl && scl_q |-> $stable(dev_sda_oe))
    else $error("device data changes while clock high");
endmodule

`default_nettype wire

// ---- tb/i2c_register_burst_access_bench.sv ----
// Burst write and read tests across both link ends
`timescale 1ns/1ps
`default_nettype none

module i2c_register_burst_access_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic load_valid = 1'h0;
  logic [7:0] load_addr = 8'h0;
  logic [15:0] load_data = 16'h0;
  logic [7:0] peek_addr = 8'h0;
  logic cmd_valid = 1'h0;
  logic cmd_read = 1'h0;
  logic [7:0] cmd_ptr = 8'h0;
  logic [7:0] cmd_len = 8'h0;
  logic wr_valid = 1'h0;
  logic [7:0] wr_data = 8'h0;
  logic rd_ready = 1'h0;
  logic load_ready;
  logic [15:0] peek_data;
  logic busy;
  logic cmd_ready;
  logic wr_ready;
  logic rd_valid;
  logic [7:0] rd_data;
  logic done;
  logic nack_err;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int done_cnt = 0;
  logic [7:0] q[$];

  // ==========================================
  // Ends, link and checker
  i2c_burst_if i2c_burst_if_i ();

  i2c_burst_device i2c_burst_device_i (.clk(clk), .rst(rst), .bus(i2c_burst_if_i), .load_valid(load_valid),
    .load_ready(load_ready), .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr),
    .peek_data(peek_data), .busy(busy));

  i2c_burst_host i2c_burst_host_i (.clk(clk), .rst(rst), .bus(i2c_burst_if_i), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .done(done), .nack_err(nack_err));

  i2c_burst_properties i2c_burst_properties_i (.clk(clk), .rst(rst), .host_sda_oe(i2c_burst_if_i.host_sda_oe),
    .dev_sda_oe(i2c_burst_if_i.dev_sda_oe), .scl(i2c_burst_if_i.scl), .sda(i2c_burst_if_i.sda));

  // ==========================================
  // Clock, completion count and hang guard
  always #50 clk = ~clk;

  always @(posedge clk) begin
    if (done === 1'b1) done_cnt <= done_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end

  // ==========================================
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Local word load, held until the device takes it
  task automatic load(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    load_valid <= 1'b1;
    load_addr <= a;
    load_data <= d;
    @(negedge clk);
    while (load_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    load_valid <= 1'b0;
  endtask

  task automatic peek(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    peek_addr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(peek_data, exp);
  endtask

  // One frame: command, then the bytes in q, optionally stalling before the first byte is offered
  task automatic xfer(input logic rd, input logic [7:0] ptr, input int stall);
    int n0;
    int i;
    n0 = done_cnt;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_ptr <= ptr;
    cmd_len <= 8'(q.size());
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (stall) @(posedge clk);
    for (i = 0; i < q.size(); i++) begin
      rd_ready <= rd;
      wr_valid <= !rd;
      wr_data <= q[i];
      @(negedge clk);
      while ((rd ? rd_valid : wr_ready) !== 1'b1) @(negedge clk);
      if (rd) chk({8'h00, rd_data}, {8'h00, q[i]});
      @(posedge clk);
    end
    rd_ready <= 1'b0;
    wr_valid <= 1'b0;
    while (done_cnt == n0) @(posedge clk);
    repeat (8) @(posedge clk);
    chk({14'h0, nack_err, busy}, 16'h0);
  endtask

  // ==========================================
  // Test sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    load(8'h12, 16'h5A6B);
    load(8'hF0, 16'h0F0F);
    load(8'h00, 16'h4321);
    load(8'hFF, 16'h8765);
    q = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
    xfer(1'h0, 8'h10, 0);
    peek(8'h10, 16'hB2A1);
    peek(8'h11, 16'hD4C3);
    $display("test 1 burst write finished");
    q = '{8'hC3, 8'hD4, 8'h6B, 8'h5A};
    // Stall past the second byte so both buffer entries fill and the clock is held low
    xfer(1'h1, 8'h11, 6000);
    $display("test 2 stalled burst read finished");
    q = '{8'h11, 8'h22};
    xfer(1'b0, 8'hF0, 0);
    peek(8'hF0, 16'h0F0F);
    $display("test 3 read-only write finished");
    q = '{8'h01, 8'h02, 8'h03, 8'h04};
    xfer(1'b0, 8'hFF, 0);
    peek(8'hFF, 16'h8765);
    peek(8'h00, 16'h4321);
    $display("test 4 write past top finished");
    q = '{8'h65, 8'h87, 8'hFF, 8'hFF};
    xfer(1'b1, 8'hFF, 0);
    $display("test 5 read past top finished");
    end_sim();
  end
endmodule

`default_nettype wire
